// ===== dpt_pkg.sv
// Package for the datapath self-test block: register indices, field
// positions, reset values, state encodings and the sample carrier.
// Assumes a 32-bit AXI4-Lite bus where each register index is one word.
package dpt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_SEQ_CTRL   = 10'h14B;
  localparam logic [9:0] IDX_ERR_REAL   = 10'h14C;
  localparam logic [9:0] IDX_ERR_IMAG   = 10'h14D;
  localparam logic [9:0] IDX_CONST_HIGH = 10'h14E;
  localparam logic [9:0] IDX_CONST_LOW  = 10'h14F;
  localparam logic [9:0] IDX_DIGITAL_TEST_CONTROL   = 10'h150;
  localparam logic [9:0] IDX_DECODER    = 10'h151;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h160;
  localparam logic [9:0] IDX_IRQ_MASK   = 10'h161;

  // Sequence checker control fields
  localparam int BIT_CHK_ENABLE  = 0;
  localparam int BIT_CNT_CLEAR   = 1;
  localparam int BIT_POLY_SELECT = 2;
  localparam int BIT_INV_REAL    = 3;
  localparam int BIT_INV_IMAG    = 4;
  localparam int BIT_OK_REAL     = 6;
  localparam int BIT_OK_IMAG     = 7;
  localparam logic [4:0] SEQ_CTRL_RESET = 5'h10;

  // Digital test control fields
  localparam int BIT_DIG_SPARE   = 0;
  localparam int BIT_CONST_EN    = 1;

  // Interrupt status bits
  localparam int BIT_IRQ_ERR_REAL = 0;
  localparam int BIT_IRQ_ERR_IMAG = 1;

  // Polynomial taps, counted back from the newest bit
  localparam int TAP7_A  = 6;
  localparam int TAP7_B  = 7;
  localparam int TAP15_A = 14;
  localparam int TAP15_B = 15;

  localparam int SAMPLE_WIDTH = 16;
  localparam int HIST_WIDTH   = 15;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] COUNT_MAX   = 8'hFF;

  // Bus channel states
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_RESP = 2'b01
  } dpt_chan_state_type;

  // One converter sample pair
  typedef struct packed {
    logic                    valid;
    logic [SAMPLE_WIDTH-1:0] re;
    logic [SAMPLE_WIDTH-1:0] im;
  } dpt_sample_type;

endpackage : dpt_pkg

// ===== dpt_seq_checker.sv
// One channel of the pseudo-random sequence checker.
// Assumes each valid word holds 16 consecutive sequence bits, MSB first,
// from logic on the same clock.
`timescale 1ns/1ps
module dpt_seq_checker
  import dpt_pkg::*;
(
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Control
  input  wire logic                    enable,
  input  wire logic                    clear,
  input  wire logic                    poly_select,
  input  wire logic                    invert,
  // Sample stream
  input  wire logic                    valid,
  input  wire logic [SAMPLE_WIDTH-1:0] data,
  // Results
  output logic      [7:0]              count,
  output logic                         seq_ok,
  output logic                         err_pulse
);

  logic [HIST_WIDTH-1:0]   hist;
  logic                    armed;
  logic [SAMPLE_WIDTH-1:0] word;
  logic                    bad;

  // Self-synchronising check: each bit is compared with taps of earlier bits
  function automatic logic [SAMPLE_WIDTH-1:0] seq_miss(
    input logic [HIST_WIDTH-1:0]   h,
    input logic [SAMPLE_WIDTH-1:0] w,
    input logic                    long_poly
  );
    logic [HIST_WIDTH+SAMPLE_WIDTH-1:0] s;
    logic [SAMPLE_WIDTH-1:0]            r;
    s = {h, w};
    r = '0;
    for (int k = 0; k < SAMPLE_WIDTH; k++)
    begin
      if (long_poly)
        r[k] = s[k] ^ s[k+TAP15_A] ^ s[k+TAP15_B];
      else
        r[k] = s[k] ^ s[k+TAP7_A] ^ s[k+TAP7_B];
    end
    return r;
  endfunction : seq_miss

  assign word = data ^ {SAMPLE_WIDTH{invert}};
  assign bad  = |seq_miss(hist, word, poly_select);

  // History; first word after enable only primes it
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !enable || clear)
    begin
      hist  <= '0;
      armed <= 1'b0;
    end
    else if (valid)
    begin
      hist  <= word[HIST_WIDTH-1:0];
      armed <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
      count <= '0;
    else if (enable && valid && armed && bad && count != COUNT_MAX)
      count <= count + 8'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      seq_ok <= 1'b0;
    else if (enable && valid && armed)
      seq_ok <= !bad;
  end

  // Error event for the interrupt logic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      err_pulse <= 1'b0;
    else
      err_pulse <= enable && !clear && valid && armed && bad;
  end

  property p_clear_zero;
    @(posedge aclk) disable iff (!aresetn)
    clear |=> count == 8'h00;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("count not cleared");

  property p_hold_disabled;
    @(posedge aclk) disable iff (!aresetn)
    !enable && !clear |=> $stable(count);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled) else $error("count moved while off");

  property p_count_step;
    @(posedge aclk) disable iff (!aresetn)
    enable && !clear && valid && armed && bad && count < COUNT_MAX
      |=> count == $past(count) + 8'h01 && err_pulse;
  endproperty
  a_count_step: assert property (p_count_step) else $error("mismatch not counted");

  property p_ok_tracks;
    @(posedge aclk) disable iff (!aresetn)
    enable && valid && armed |=> seq_ok == !$past(bad);
  endproperty
  a_ok_tracks: assert property (p_ok_tracks) else $error("good flag wrong");

  property p_poly_taps;
    @(posedge aclk) disable iff (!aresetn)
    enable && !clear && valid && armed && !poly_select
      && (word[0] == (word[TAP7_A] ^ word[TAP7_B]))
      && (word[8] != (word[8+TAP7_A] ^ word[8+TAP7_B])) |=> err_pulse;
  endproperty
  a_poly_taps: assert property (p_poly_taps) else $error("short poly miss lost");

endmodule : dpt_seq_checker

// ===== dpt_self_test.sv
// What this block does
// - Control bit 3 makes the real checker expect the inverted sequence when set.
// - Control bit 4 does the same for the imaginary channel and resets to one.
// - Control bit 2 picks x^7+x^6+1 at zero and x^15+x^14+1 at one.
// - With bit 0 set, real mismatches are counted; bit 1 at one clears counters.
// - A separate imaginary count shares that clear and counts only while enabled.
// - Good-data flags at bits 6 and 7 show the last checked word was right.
// - A 16-bit constant word sits in a high and a low byte register.
// - With constant-test enable bit 1 set the constant replaces the sample data.
// - On the 11-bit variant the constant-test registers have no effect.
//
// Top of the datapath self-test block: AXI4-Lite slave, control registers,
// two sequence checkers, constant-word substitution and an interrupt.
// Assumes samples arrive from logic on aclk; one clock, synchronous reset.
`timescale 1ns/1ps
module dpt_self_test
  import dpt_pkg::*;
#(
  parameter bit SHORT_VARIANT = 1'b0
)
(
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address and data
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Sample stream from the link transmitter
  input  wire dpt_sample_type       sample_in,
  // Data to the converter
  output dpt_sample_type            dac_out,
  // Interrupt
  output logic                      irq
);

  // Register state
  logic [4:0]         seq_ctrl;
  logic [7:0]         const_high;
  logic [7:0]         const_low;
  logic [1:0]         digital_test_control;
  logic [7:0]         decoder_ctrl;
  logic [1:0]         irq_status;
  logic [1:0]         irq_mask;

  // Checker results
  logic [7:0]         count_real;
  logic [7:0]         count_imag;
  logic               ok_real;
  logic               ok_imag;
  logic               err_real;
  logic               err_imag;

  // Write channel
  dpt_chan_state_type wr_state;
  logic               aw_held;
  logic               w_held;
  logic [11:0]        aw_addr;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic               wr_fire;
  logic               wr_hit;

  // Read channel
  dpt_chan_state_type rd_state;
  logic [31:0]        next_rdata;
  logic               rd_hit;

  logic [SAMPLE_WIDTH-1:0] const_word;
  logic                    const_active;

  // Word index decode shared by both channels
  function automatic logic idx_is(input logic [11:0] addr, input logic [9:0] idx);
    return addr[11:2] == idx;
  endfunction : idx_is

  function automatic logic idx_known(input logic [11:0] addr);
    return idx_is(addr, IDX_SEQ_CTRL) || idx_is(addr, IDX_ERR_REAL)
        || idx_is(addr, IDX_ERR_IMAG) || idx_is(addr, IDX_CONST_HIGH)
        || idx_is(addr, IDX_CONST_LOW) || idx_is(addr, IDX_DIGITAL_TEST_CONTROL)
        || idx_is(addr, IDX_DECODER) || idx_is(addr, IDX_IRQ_STATUS)
        || idx_is(addr, IDX_IRQ_MASK);
  endfunction : idx_known

  // Address and data are taken independently, each only once per write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
      else
      begin
        if (s_axi_awvalid && !aw_held && !s_axi_awready && wr_state == CH_IDLE)
        begin
          s_axi_awready <= 1'b1;
          aw_held       <= 1'b1;
          aw_addr       <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held && !s_axi_wready && wr_state == CH_IDLE)
        begin
          s_axi_wready <= 1'b1;
          w_held       <= 1'b1;
          w_data       <= s_axi_wdata;
          w_strb       <= s_axi_wstrb;
        end
      end
    end
  end

  assign wr_fire = aw_held && w_held && wr_state == CH_IDLE;
  assign wr_hit  = idx_known(aw_addr);

  // Write response; unmapped indices answer SLVERR and store nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state     <= CH_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      case (wr_state)
        CH_IDLE:
        begin
          if (wr_fire)
          begin
            wr_state     <= CH_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        CH_RESP:
        begin
          if (s_axi_bready)
          begin
            wr_state     <= CH_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default:
          wr_state <= CH_IDLE;
      endcase
    end
  end

  // Control register writes; only byte lane 0 carries register bits
  // imaginary inversion resets set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seq_ctrl     <= SEQ_CTRL_RESET;
      digital_test_control     <= '0;
      decoder_ctrl <= '0;
      irq_mask     <= '0;
    end
    else if (wr_fire && w_strb[0])
    begin
      if (idx_is(aw_addr, IDX_SEQ_CTRL))
        seq_ctrl <= w_data[BIT_INV_IMAG:BIT_CHK_ENABLE];
      if (idx_is(aw_addr, IDX_DIGITAL_TEST_CONTROL))
        digital_test_control <= w_data[BIT_CONST_EN:BIT_DIG_SPARE];
      if (idx_is(aw_addr, IDX_DECODER))
        decoder_ctrl <= w_data[7:0];
      if (idx_is(aw_addr, IDX_IRQ_MASK))
        irq_mask <= w_data[BIT_IRQ_ERR_IMAG:BIT_IRQ_ERR_REAL];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      const_high <= '0;
      const_low  <= '0;
    end
    else if (wr_fire && w_strb[0])
    begin
      if (idx_is(aw_addr, IDX_CONST_HIGH))
        const_high <= w_data[7:0];
      if (idx_is(aw_addr, IDX_CONST_LOW))
        const_low <= w_data[7:0];
    end
  end

  // Sticky error status, write one to clear; a new error wins over the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status <= '0;
    else
    begin
      if (wr_fire && w_strb[0] && idx_is(aw_addr, IDX_IRQ_STATUS))
        irq_status <= (irq_status & ~w_data[BIT_IRQ_ERR_IMAG:BIT_IRQ_ERR_REAL])
                    | {err_imag, err_real};
      else
        irq_status <= irq_status | {err_imag, err_real};
    end
  end

  // Level interrupt, registered so the pin is glitch free
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  // Read data mux; reserved bits read as zero
  always_comb
  begin
    next_rdata = '0;
    if (idx_is(s_axi_araddr, IDX_SEQ_CTRL))
      next_rdata[7:0] = {ok_imag, ok_real, 1'b0, seq_ctrl};
    else if (idx_is(s_axi_araddr, IDX_ERR_REAL))
      next_rdata[7:0] = count_real;
    else if (idx_is(s_axi_araddr, IDX_ERR_IMAG))
      next_rdata[7:0] = count_imag;
    else if (idx_is(s_axi_araddr, IDX_CONST_HIGH))
      next_rdata[7:0] = const_high;
    else if (idx_is(s_axi_araddr, IDX_CONST_LOW))
      next_rdata[7:0] = const_low;
    else if (idx_is(s_axi_araddr, IDX_DIGITAL_TEST_CONTROL))
      next_rdata[1:0] = digital_test_control;
    else if (idx_is(s_axi_araddr, IDX_DECODER))
      next_rdata[7:0] = decoder_ctrl;
    else if (idx_is(s_axi_araddr, IDX_IRQ_STATUS))
      next_rdata[1:0] = irq_status;
    else if (idx_is(s_axi_araddr, IDX_IRQ_MASK))
      next_rdata[1:0] = irq_mask;
  end

  assign rd_hit = idx_known(s_axi_araddr);

  // Read channel: address taken and data returned on the same edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state      <= CH_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      case (rd_state)
        CH_IDLE:
        begin
          s_axi_arready <= 1'b1;
          if (s_axi_arvalid && s_axi_arready)
          begin
            rd_state      <= CH_RESP;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        CH_RESP:
        begin
          if (s_axi_rready)
          begin
            rd_state     <= CH_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default:
          rd_state <= CH_IDLE;
      endcase
    end
  end

  dpt_seq_checker u_check_real (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .enable      (seq_ctrl[BIT_CHK_ENABLE]),
    .clear       (seq_ctrl[BIT_CNT_CLEAR]),
    .poly_select (seq_ctrl[BIT_POLY_SELECT]),
    .invert      (seq_ctrl[BIT_INV_REAL]),
    .valid       (sample_in.valid),
    .data        (sample_in.re),
    .count       (count_real),
    .seq_ok      (ok_real),
    .err_pulse   (err_real)
  );

  dpt_seq_checker u_check_imag (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .enable      (seq_ctrl[BIT_CHK_ENABLE]),
    .clear       (seq_ctrl[BIT_CNT_CLEAR]),
    .poly_select (seq_ctrl[BIT_POLY_SELECT]),
    .invert      (seq_ctrl[BIT_INV_IMAG]),
    .valid       (sample_in.valid),
    .data        (sample_in.im),
    .count       (count_imag),
    .seq_ok      (ok_imag),
    .err_pulse   (err_imag)
  );

  assign const_active = digital_test_control[BIT_CONST_EN] && !SHORT_VARIANT;
  assign const_word   = {const_high, const_low};

  // constant replaces both channels; valid still follows the stream
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dac_out <= '0;
    else if (const_active)
      dac_out <= '{valid: sample_in.valid, re: const_word, im: const_word};
    else
      dac_out <= sample_in;
  end

  property p_inv_imag_reset;
    @(posedge aclk)
    !aresetn |=> seq_ctrl[BIT_INV_IMAG] && !seq_ctrl[BIT_INV_REAL];
  endproperty
  a_inv_imag_reset: assert property (p_inv_imag_reset) else $error("inversion reset wrong");

  property p_const_out;
    @(posedge aclk) disable iff (!aresetn)
    const_active |=> dac_out.re == $past(const_word) && dac_out.im == $past(const_word);
  endproperty
  a_const_out: assert property (p_const_out) else $error("constant not driven");

  property p_pass_through;
    @(posedge aclk) disable iff (!aresetn)
    !const_active |=> dac_out == $past(sample_in);
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("stream not passed");

  property p_const_bytes;
    @(posedge aclk) disable iff (!aresetn)
    wr_fire && w_strb[0] && idx_is(aw_addr, IDX_CONST_HIGH)
      |=> const_high == $past(w_data[7:0]) ##1 const_word[15:8] == const_high;
  endproperty
  a_const_bytes: assert property (p_const_bytes) else $error("high byte not stored");

  property p_err_sticky;
    @(posedge aclk) disable iff (!aresetn)
    err_real |=> irq_status[BIT_IRQ_ERR_REAL] ##1 (irq == irq_mask[BIT_IRQ_ERR_REAL]
      || irq_status[BIT_IRQ_ERR_IMAG]);
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error event lost");

endmodule : dpt_self_test

// ===== dpt_seq_source.sv
// Far-side model: link transmitter logic sending sequence test words.
// Assumes the bench pulses start for one cycle and waits for busy to drop.
`timescale 1ns/1ps
module dpt_seq_source
  import dpt_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Command from the bench
  input  wire logic       start,
  input  wire logic [7:0] n_words,
  input  wire logic       poly,
  input  wire logic       inv_re,
  input  wire logic       inv_im,
  input  wire logic       err_re,
  input  wire logic       err_im,
  // Stream into the block
  output dpt_sample_type  sample,
  output logic            busy
);
  logic [14:0] hist;
  logic [7:0]  left;
  logic [30:0] nxt;
  logic        last;

  // Sixteen sequence bits per word, oldest in the MSB
  function automatic logic [30:0] step(input logic [14:0] h, input logic p);
    logic [15:0] w;
    logic        b;
    w = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      b = p ? (h[13] ^ h[14]) : (h[5] ^ h[6]);
      w = {w[14:0], b};
      h = {h[13:0], b};
    end
    return {h, w};
  endfunction : step

  assign nxt  = step(hist, poly);
  assign last = (left == 8'h01);

  // unbroken sequence on both lanes
  // A flipped MSB in the last word upsets that word only, for either length
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hist   <= 15'h0001;
      left   <= 8'h00;
      busy   <= 1'b0;
      sample <= '0;
    end
    else if (start && !busy)
    begin
      left <= n_words;
      busy <= 1'b1;
    end
    else if (left != 8'h00)
    begin
      sample.valid <= 1'b1;
      sample.re    <= nxt[15:0] ^ {16{inv_re}} ^ {last && err_re, 15'h0000};
      sample.im    <= nxt[15:0] ^ {16{inv_im}} ^ {last && err_im, 15'h0000};
      hist         <= nxt[30:16];
      left         <= left - 8'h01;
    end
    else
    begin
      // Idle lanes toggle so stale data never looks valid
      sample.valid <= 1'b0;
      sample.re    <= ~sample.re;
      sample.im    <= ~sample.im;
      busy         <= 1'b0;
    end
  end
endmodule : dpt_seq_source

// ===== dpt_self_test_tb.sv
// Self-checking bench: AXI4-Lite master tasks, sequence source, result queues.
// Assumes the block answers within 100 cycles of each request.
`timescale 1ns/1ps
module dpt_self_test_tb
  import dpt_pkg::*;
;
  logic           aclk = 1'b0, aresetn = 1'b0, start = 1'b0, busy, irq, exp_irq = 1'b0;
  logic           awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic           awready, wready, bvalid, arready, rvalid;
  logic           poly = 1'b0, inv_re = 1'b0, inv_im = 1'b0, er = 1'b0, ei = 1'b0;
  logic [7:0]     nw = 8'h00;
  logic [11:0]    awaddr = 12'h000, araddr = 12'h000;
  logic [31:0]    wdata = 32'h0000_0000, rdata;
  logic [1:0]     bresp, rresp;
  dpt_sample_type smp, dac;
  int             n_fail = 0, checked = 0;
  logic [34:0]    rq[$];
  logic [1:0]     wq[$];
  logic [31:0]    dq[$];
  localparam logic [9:0] ZERO_IDX [8] = '{IDX_ERR_REAL, IDX_ERR_IMAG, IDX_CONST_HIGH,
    IDX_CONST_LOW, IDX_DIGITAL_TEST_CONTROL, IDX_DECODER, IDX_IRQ_STATUS, IDX_IRQ_MASK};

  always #10 aclk = ~aclk;

  dpt_self_test DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_in(smp), .dac_out(dac), .irq(irq));

  dpt_seq_source src (.aclk(aclk), .aresetn(aresetn), .start(start), .n_words(nw),
    .poly(poly), .inv_re(inv_re), .inv_im(inv_im), .err_re(er), .err_im(ei),
    .sample(smp), .busy(busy));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic timeout();
    n_fail++;
    $display("FAIL wait expected handshake seen none");
    give_verdict();
  endtask : timeout

  task automatic chk_rd(input logic [34:0] e, input logic [34:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("FAIL read irq_resp_data expected %h seen %h", e, g);
    end
  endtask : chk_rd

  task automatic chk_wr(input logic [1:0] e, input logic [1:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("FAIL bresp expected %h seen %h", e, g);
    end
  endtask : chk_wr

  task automatic chk_dac(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("FAIL dac_out expected %h seen %h", e, g);
    end
  endtask : chk_dac

  function automatic logic flag(input int k);
    return k == 0 ? bvalid : k == 1 ? arready : k == 2 ? rvalid : !busy;
  endfunction : flag

  // Bounded wait for one handshake flag, sampled at rising edges
  task automatic wait_hi(input int k);
    int n;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (flag(k) !== 1'b1 && n < 100);
    if (flag(k) !== 1'b1)
      timeout();
  endtask : wait_hi

  // Address and data offered together, each dropped when taken
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] e);
    int   n;
    logic ga, gw;
    @(posedge aclk);
    wq.push_back(e);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    ga = 1'b0;
    gw = 1'b0;
    n = 0;
    while (!(ga && gw))
    begin
      @(posedge aclk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      ga = ga | awready;
      gw = gw | wready;
      if (n > 100)
        timeout();
    end
    wait_hi(0);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] e);
    @(posedge aclk);
    rq.push_back({exp_irq, e, 24'h00_0000, d});
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    wait_hi(1);
    arvalid <= 1'b0;
    wait_hi(2);
    rready  <= 1'b0;
  endtask : rd

  // Stream n words; irq lags a bad word by three cycles
  task automatic send(input logic [7:0] n, input logic e_re, input logic e_im);
    nw    <= n;
    er    <= e_re;
    ei    <= e_im;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    wait_hi(3);
    repeat (4) @(posedge aclk);
  endtask : send

  // Watcher: oldest note against each finished transfer
  always @(posedge aclk)
  begin
    if (rvalid && rready && rq.size() > 0)
      chk_rd(rq.pop_front(), {irq, rresp, rdata});
    if (bvalid && bready && wq.size() > 0)
      chk_wr(wq.pop_front(), bresp);
    if (dac.valid && dq.size() > 0)
      chk_dac(dq.pop_front(), {dac.re, dac.im});
  end

  initial
  begin
    logic [7:0]  ctl;
    logic [15:0] cw;
    void'($urandom(32'h42ff_afcd));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_SEQ_CTRL, 8'h10, RESP_OKAY);
    for (int i = 0; i < 8; i++)
      rd(ZERO_IDX[i], 8'h00, RESP_OKAY);
    rd(10'h3ff, 8'h00, RESP_SLVERR);
    wr(10'h3ff, 8'h5a, RESP_SLVERR);
    wr(IDX_ERR_REAL, 8'h55, RESP_OKAY);
    rd(IDX_ERR_REAL, 8'h00, RESP_OKAY);
    wr(IDX_DIGITAL_TEST_CONTROL, 8'hff, RESP_OKAY);
    rd(IDX_DIGITAL_TEST_CONTROL, 8'h03, RESP_OKAY);
    wr(IDX_DIGITAL_TEST_CONTROL, 8'h00, RESP_OKAY);
    wr(IDX_DECODER, 8'ha5, RESP_OKAY);
    rd(IDX_DECODER, 8'ha5, RESP_OKAY);
    $display("test registers done");
    // Both polynomials with exactly one lane inverted; bad last real word except for c == 1, bad last imaginary word for c >= 2
    wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
    for (int c = 0; c < 4; c++)
    begin
      poly   <= c[0];
      inv_re <= c[1];
      inv_im <= !c[1];
      ctl = {3'b000, !c[1], c[1], c[0], 2'b00};
      wr(IDX_SEQ_CTRL, ctl | 8'h02, RESP_OKAY);
      wr(IDX_SEQ_CTRL, ctl | 8'h01, RESP_OKAY);
      send(8'd20, c != 1, c[1]);
      exp_irq = (c == 0);
      rd(IDX_ERR_REAL, {7'h00, c != 1}, RESP_OKAY);
      rd(IDX_ERR_IMAG, {7'h00, c[1]}, RESP_OKAY);
      rd(IDX_SEQ_CTRL, {!c[1], c == 1, ctl[5:0] | 6'h01}, RESP_OKAY);
      if (c == 0)
      begin
        wr(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
        exp_irq = 1'b0;
        rd(IDX_IRQ_STATUS, 8'h00, RESP_OKAY);
        wr(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
      end
    end
    rd(IDX_IRQ_STATUS, 8'h03, RESP_OKAY);
    wr(IDX_IRQ_MASK, 8'h03, RESP_OKAY);
    exp_irq = 1'b1;
    rd(IDX_IRQ_STATUS, 8'h03, RESP_OKAY);
    wr(IDX_IRQ_STATUS, 8'h03, RESP_OKAY);
    exp_irq = 1'b0;
    rd(IDX_IRQ_STATUS, 8'h00, RESP_OKAY);
    // Disabled checker must leave the counts alone
    wr(IDX_SEQ_CTRL, 8'h0c, RESP_OKAY);
    send(8'd20, 1'b1, 1'b1);
    rd(IDX_ERR_REAL, 8'h01, RESP_OKAY);
    rd(IDX_ERR_IMAG, 8'h01, RESP_OKAY);
    $display("test sequence checker done");
    cw = 16'($urandom);
    wr(IDX_CONST_HIGH, cw[15:8], RESP_OKAY);
    wr(IDX_CONST_LOW, cw[7:0], RESP_OKAY);
    rd(IDX_CONST_HIGH, cw[15:8], RESP_OKAY);
    rd(IDX_CONST_LOW, cw[7:0], RESP_OKAY);
    wr(IDX_DIGITAL_TEST_CONTROL, 8'h02, RESP_OKAY);
    repeat (8) dq.push_back({cw, cw});
    send(8'd8, 1'b0, 1'b0);
    if (dq.size() != 0)
    begin
      n_fail++;
      $display("FAIL dac_backlog expected 0 seen %0d", dq.size());
    end
    wr(IDX_DIGITAL_TEST_CONTROL, 8'h00, RESP_OKAY);
    $display("test constant word done");
    give_verdict();
  end
endmodule : dpt_self_test_tb
